// File: rtl/cass_defines.svh
// constants of the architectural state sequencer
// assumes 100 MHz pclk and 32-bit apb data
`ifndef CASS_DEFINES_SVH
`define CASS_DEFINES_SVH
`define CASS_CLK_NS      10
`define CASS_RTC_NS      1843200
`define CASS_RTC_CYCLES  (`CASS_RTC_NS / `CASS_CLK_NS)
`define CASS_ROWS        64
`define CASS_CNT_W       20
`define CASS_IO_HALF     4
`define CASS_IO_BITS     8
`define CASS_SAVE_LOC    15'h0000
`define CASS_VEC_LOC     15'h0001
`define CASS_A_ACC0      8'h00
`define CASS_A_ACC3      8'h0c
`define CASS_A_IP        8'h10
`define CASS_A_SP        8'h14
`define CASS_A_FP        8'h18
`define CASS_A_FLAGS     8'h1c
`define CASS_A_STATUS    8'h20
`define CASS_A_INSTR     8'h24
`define CASS_A_CMD       8'h28
`define CASS_A_TARGET    8'h2c
`define CASS_A_DCHADR    8'h30
`define CASS_F_CARRY     0
`define CASS_F_IEN       1
`define CASS_F_PCEN      2
`define CASS_C_TEST      4
`define CASS_C_DST       9:8
`define CASS_C_SRC       11:10
`endif

// File: rtl/cass_pkg.sv
// types of the architectural state sequencer
// needs cass_defines.svh for the counter width
`include "cass_defines.svh"
package cass_pkg;
    typedef enum logic [3:0] {S_BOUND, S_RADDR, S_RDATA, S_WADDR, S_WDATA,
                              S_EXEC, S_REFR, S_DCH} cass_state_e;
    typedef enum logic [2:0] {MEM_IDLE, MEM_READ, MEM_WRITE, MEM_RMW,
                              MEM_REFRESH} cass_mem_e;
    typedef enum logic [3:0] {OP_NONE, OP_NEXT, OP_SKIP, OP_JUMP, OP_HALT,
                              OP_PUSH, OP_POP, OP_RET, OP_ADD} cass_op_e;
    typedef enum logic {RD_FETCH, RD_VEC} cass_rd_e;
    typedef enum logic {WR_SAVE, WR_DCH} cass_wr_e;
    typedef struct packed {
        logic [3:0][15:0]      acc;
        logic [14:0]           ip;
        logic [14:0]           sp;
        logic [14:0]           fp;
        logic [14:0]           target;
        logic [14:0]           dch_adr;
        logic                  carry;
        logic                  ien;
        logic                  pcen;
        logic                  periodic_clock_request_flag;
        logic                  stack_overflow_request_flag;
        logic                  rf_rq;
        logic                  halted;
        logic [5:0]            row;
        logic [`CASS_CNT_W-1:0] rtc_cnt;
        logic [`CASS_CNT_W-1:0] rf_cnt;
        logic [15:0]           instr;
        logic [15:0]           wdat;
        logic [7:0]            sh_hi;
        logic [7:0]            sh_lo;
        logic [3:0]            bitn;
        logic [2:0]            ph;
        logic [3:0]            s1;
        logic [3:0]            s2;
        logic [3:0]            s3;
        logic [3:0]            filt;
        cass_state_e           state;
        cass_rd_e              rd_kind;
        cass_wr_e              wr_kind;
        logic [15:0]           mem_ad;
        logic                  mem_oe;
        cass_mem_e             mem_ctl;
        logic                  io_clk;
        logic                  io_dir;
        logic [31:0]           prdata;
        logic                  pready;
        logic                  pslverr;
    } cass_st_s;
endpackage : cass_pkg

// File: rtl/cass_core.sv
// architectural state, program sequencing, refresh and data channel
// assumes synchronous memory on pclk and an apb master on pclk
`timescale 1ns/1ps
`include "cass_defines.svh"
module cass_core #(
    parameter int unsigned RTC_CYCLES = `CASS_RTC_CYCLES,
    parameter int unsigned RF_CYCLES  = RTC_CYCLES / `CASS_ROWS
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] mem_ad_i,
    output logic      [15:0] mem_ad_o,
    output logic             mem_ad_oe,
    output logic      [2:0]  mem_ctl,
    input  wire logic        io_d1_i,
    output logic             io_d1_o,
    output logic             io_d1_oe,
    input  wire logic        io_d2_i,
    output logic             io_d2_o,
    output logic             io_d2_oe,
    output logic             io_dir,
    output logic             io_clk,
    input  wire logic        pio_req_n,
    input  wire logic        dch_req_n,
    output logic             halted
);
    localparam logic [`CASS_CNT_W-1:0] RTC_LAST = `CASS_CNT_W'(RTC_CYCLES - 1);
    localparam logic [`CASS_CNT_W-1:0] RF_LAST  = `CASS_CNT_W'(RF_CYCLES - 1);
    cass_pkg::cass_st_s q;
    cass_pkg::cass_st_s n;
    logic        pio;
    logic        dch;
    logic        irq;
    logic        rtc_tick;
    logic        rf_tick;
    logic        clr_rtc;
    logic        clr_so;
    logic        clr_rf;
    logic        so_set;
    logic        cmd_wr;
    logic [3:0]  op;
    logic [14:0] sp_up;
    logic [16:0] sum;
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'b00) && (a <= `CASS_A_DCHADR);
    endfunction : mapped
    function automatic logic [31:0] rd_mux(input cass_pkg::cass_st_s s,
                                           input logic [7:0] a);
        rd_mux = 32'h0;
        case (a)
            `CASS_A_IP:     rd_mux = {17'h0, s.ip};
            `CASS_A_SP:     rd_mux = {17'h0, s.sp};
            `CASS_A_FP:     rd_mux = {17'h0, s.fp};
            `CASS_A_FLAGS:  rd_mux = {29'h0, s.pcen, s.ien, s.carry};
            `CASS_A_STATUS: rd_mux = {18'h0, s.row, 4'h0, s.rf_rq, s.halted,
                                      s.stack_overflow_request_flag, s.periodic_clock_request_flag};
            `CASS_A_INSTR:  rd_mux = {16'h0, s.instr};
            `CASS_A_TARGET: rd_mux = {17'h0, s.target};
            `CASS_A_DCHADR: rd_mux = {17'h0, s.dch_adr};
            default: begin
                if (a <= `CASS_A_ACC3) begin
                    rd_mux = {16'h0, s.acc[a[3:2]]};
                end
            end
        endcase
    endfunction : rd_mux
    always_comb begin
        n = q;
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        // request lines and serial data synchronised
        n.s1 = {dch_req_n, pio_req_n, io_d2_i, io_d1_i};
        n.s2 = q.s1;
        n.s3 = q.s2;
        n.filt = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.filt);
        pio = ~q.filt[2];
        dch = ~q.filt[3];
        // periodic timer runs only when enabled
        rtc_tick = q.pcen && (q.rtc_cnt == RTC_LAST);
        n.rtc_cnt = (!q.pcen || rtc_tick) ? '0 : q.rtc_cnt + 1'b1;
        rf_tick = (q.rf_cnt == RF_LAST);
        n.rf_cnt = rf_tick ? '0 : q.rf_cnt + 1'b1;
        irq = q.ien && (pio || (q.periodic_clock_request_flag && q.pcen) || q.stack_overflow_request_flag);
        clr_rtc = 1'b0;
        clr_so = 1'b0;
        clr_rf = 1'b0;
        so_set = 1'b0;
        sp_up = q.sp + 15'h1;
        sum = 17'h0;
        if (psel && penable && !q.pready) begin
            n.pready = 1'b1;
            n.pslverr = !mapped(paddr);
            n.prdata = pwrite ? 32'h0 : rd_mux(q, paddr);
        end
        cmd_wr = psel && penable && q.pready && pwrite && !q.pslverr &&
                 (paddr == `CASS_A_CMD);
        op = cmd_wr ? pwdata[3:0] : 4'h0;
        if (psel && penable && q.pready && pwrite && !q.pslverr) begin
            case (paddr)
                `CASS_A_IP:     n.ip = pwdata[14:0];
                `CASS_A_SP:     n.sp = pwdata[14:0];
                `CASS_A_FP:     n.fp = pwdata[14:0];
                `CASS_A_FLAGS: begin
                    n.carry = pwdata[`CASS_F_CARRY];
                    n.ien = pwdata[`CASS_F_IEN];
                    n.pcen = pwdata[`CASS_F_PCEN];
                end
                `CASS_A_TARGET: n.target = pwdata[14:0];
                `CASS_A_DCHADR: n.dch_adr = pwdata[14:0];
                default: begin
                    if (paddr <= `CASS_A_ACC3) begin
                        n.acc[paddr[3:2]] = pwdata[15:0];
                    end
                end
            endcase
        end
        case (op)
            // push raises pointer, watch page crossing
            cass_pkg::OP_PUSH: begin
                n.sp = sp_up;
                so_set = (sp_up[14:8] != q.sp[14:8]);
            end
            cass_pkg::OP_POP: n.sp = q.sp - 15'h1;
            cass_pkg::OP_RET: n.sp = q.fp;
            // accumulators feed the adder, carry out
            cass_pkg::OP_ADD: begin
                sum = {1'b0, q.acc[pwdata[`CASS_C_DST]]} +
                      {1'b0, q.acc[pwdata[`CASS_C_SRC]]};
                n.acc[pwdata[`CASS_C_DST]] = sum[15:0];
                n.carry = sum[16];
            end
            default: ;
        endcase
        case (q.state)
            cass_pkg::S_BOUND: begin
                n.mem_ctl = cass_pkg::MEM_IDLE;
                n.mem_oe = 1'b0;
                if (q.rf_rq) begin
                    clr_rf = 1'b1;
                    n.mem_ctl = cass_pkg::MEM_REFRESH;
                    n.mem_oe = 1'b1;
                    n.mem_ad = {10'h0, q.row};
                    n.state = cass_pkg::S_REFR;
                end else if (dch) begin
                    n.io_dir = 1'b1;
                    n.io_clk = 1'b0;
                    n.ph = 3'h0;
                    n.bitn = 4'h0;
                    n.state = cass_pkg::S_DCH;
                end else if (irq) begin
                    clr_rtc = q.periodic_clock_request_flag && q.pcen;
                    clr_so = 1'b1;
                    n.ien = 1'b0;
                    n.halted = 1'b0;
                    n.wr_kind = cass_pkg::WR_SAVE;
                    n.wdat = {1'b0, q.ip};
                    n.mem_ad = {1'b0, `CASS_SAVE_LOC};
                    n.mem_oe = 1'b1;
                    n.mem_ctl = cass_pkg::MEM_WRITE;
                    n.state = cass_pkg::S_WADDR;
                end else if (!q.halted) begin
                    n.rd_kind = cass_pkg::RD_FETCH;
                    n.mem_ad = {1'b0, q.ip};
                    n.mem_oe = 1'b1;
                    n.mem_ctl = cass_pkg::MEM_READ;
                    n.state = cass_pkg::S_RADDR;
                end
            end
            cass_pkg::S_RADDR: begin
                n.mem_oe = 1'b0;
                n.state = cass_pkg::S_RDATA;
            end
            cass_pkg::S_RDATA: begin
                n.mem_ctl = cass_pkg::MEM_IDLE;
                if (q.rd_kind == cass_pkg::RD_FETCH) begin
                    // word read back is the instruction
                    n.instr = mem_ad_i;
                    n.state = cass_pkg::S_EXEC;
                end else begin
                    n.ip = mem_ad_i[14:0];
                    n.state = cass_pkg::S_BOUND;
                end
            end
            cass_pkg::S_WADDR: begin
                // data follows address on the shared bus
                n.mem_ad = q.wdat;
                n.state = cass_pkg::S_WDATA;
            end
            cass_pkg::S_WDATA: begin
                n.mem_ctl = cass_pkg::MEM_IDLE;
                n.mem_oe = 1'b0;
                n.state = cass_pkg::S_BOUND;
                if (q.wr_kind == cass_pkg::WR_SAVE) begin
                    n.rd_kind = cass_pkg::RD_VEC;
                    n.mem_ad = {1'b0, `CASS_VEC_LOC};
                    n.mem_oe = 1'b1;
                    n.mem_ctl = cass_pkg::MEM_READ;
                    n.state = cass_pkg::S_RADDR;
                end
            end
            cass_pkg::S_EXEC: begin
                // refresh goes on while a command is awaited
                clr_rf = q.rf_rq && (q.mem_ctl == cass_pkg::MEM_IDLE);
                n.mem_ctl = clr_rf ? cass_pkg::MEM_REFRESH : cass_pkg::MEM_IDLE;
                n.mem_oe = clr_rf;
                n.mem_ad = clr_rf ? {10'h0, q.row} : q.mem_ad;
                n.row = q.row + {5'h0, clr_rf};
                case (op)
                    cass_pkg::OP_NEXT: n.ip = q.ip + 15'h1;
                    cass_pkg::OP_SKIP: n.ip = q.ip + (pwdata[`CASS_C_TEST] ? 15'h2 : 15'h1);
                    cass_pkg::OP_JUMP: n.ip = q.target;
                    cass_pkg::OP_HALT: begin
                        n.ip = q.ip + 15'h1;
                        n.halted = 1'b1;
                    end
                    default: ;
                endcase
                if (op inside {cass_pkg::OP_NEXT, cass_pkg::OP_SKIP,
                               cass_pkg::OP_JUMP, cass_pkg::OP_HALT}) begin
                    n.state = cass_pkg::S_BOUND;
                end
            end
            cass_pkg::S_REFR: begin
                n.row = q.row + 6'h1;
                n.mem_ctl = cass_pkg::MEM_IDLE;
                n.mem_oe = 1'b0;
                n.state = cass_pkg::S_BOUND;
            end
            cass_pkg::S_DCH: begin
                // clocked serial word in, two lines per bit
                n.ph = q.ph + 3'h1;
                if (q.ph == 3'(`CASS_IO_HALF - 1)) begin
                    n.io_clk = 1'b1;
                end
                if (q.ph == 3'(2 * `CASS_IO_HALF - 1)) begin
                    n.io_clk = 1'b0;
                    // first line carries the high byte
                    n.sh_hi = {q.sh_hi[6:0], q.filt[0]};
                    n.sh_lo = {q.sh_lo[6:0], q.filt[1]};
                    n.bitn = q.bitn + 4'h1;
                    if (q.bitn == 4'(`CASS_IO_BITS - 1)) begin
                        n.io_dir = 1'b0;
                        n.wr_kind = cass_pkg::WR_DCH;
                        n.wdat = {q.sh_hi[6:0], q.filt[0], q.sh_lo[6:0], q.filt[1]};
                        n.mem_ad = {1'b0, q.dch_adr};
                        n.dch_adr = q.dch_adr + 15'h1;
                        n.mem_oe = 1'b1;
                        n.mem_ctl = cass_pkg::MEM_WRITE;
                        n.state = cass_pkg::S_WADDR;
                    end
                end
            end
            default: n.state = cass_pkg::S_BOUND;
        endcase
        // hardware set wins over clear
        n.periodic_clock_request_flag = rtc_tick || (q.periodic_clock_request_flag && !clr_rtc);
        n.stack_overflow_request_flag = so_set || (q.stack_overflow_request_flag && !clr_so);
        n.rf_rq = rf_tick || (q.rf_rq && !clr_rf);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.filt <= 4'hc;
            q.s1 <= 4'hc;
            q.s2 <= 4'hc;
            q.s3 <= 4'hc;
            // start halted until an interrupt is taken
            q.halted <= 1'b1;
        end else begin
            q <= n;
        end
    end
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign mem_ad_o = q.mem_ad;
    assign mem_ad_oe = q.mem_oe;
    assign mem_ctl = q.mem_ctl;
    assign io_dir = q.io_dir;
    assign io_clk = q.io_clk;
    assign io_d1_o = 1'b0;
    assign io_d1_oe = 1'b0;
    assign io_d2_o = 1'b0;
    assign io_d2_oe = 1'b0;
    assign halted = q.halted;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_fetch_addr: assert property (
        (q.state == cass_pkg::S_RADDR && q.rd_kind == cass_pkg::RD_FETCH)
        |-> (mem_ad_oe && mem_ctl == 3'(cass_pkg::MEM_READ) && mem_ad_o == {1'b0, q.ip}))
        else $error("fetch address not the pc");
    chk_fetch_data: assert property (
        (q.state == cass_pkg::S_RDATA && q.rd_kind == cass_pkg::RD_FETCH)
        |=> (q.state == cass_pkg::S_EXEC && q.instr == $past(mem_ad_i)))
        else $error("instruction not taken");
    chk_pc_next: assert property (
        (q.state == cass_pkg::S_EXEC && op == 4'(cass_pkg::OP_NEXT))
        |=> q.ip == 15'($past(q.ip) + 15'h1))
        else $error("pc did not advance by one");
    chk_skip_two: assert property (
        (q.state == cass_pkg::S_EXEC && op == 4'(cass_pkg::OP_SKIP) && pwdata[`CASS_C_TEST])
        |=> q.ip == 15'($past(q.ip) + 15'h2))
        else $error("true skip did not add two");
    chk_push_cross: assert property (
        (op == 4'(cass_pkg::OP_PUSH) && q.sp[7:0] == 8'hff) |=> q.stack_overflow_request_flag)
        else $error("overflow request missing");
    chk_ext_gated: assert property (
        (q.state == cass_pkg::S_BOUND && !q.ien)
        |=> !(q.state == cass_pkg::S_WADDR && q.wr_kind == cass_pkg::WR_SAVE))
        else $error("interrupt taken while disabled");
    chk_rtc_enable: assert property (
        $rose(q.periodic_clock_request_flag) |-> $past(q.pcen))
        else $error("periodic request while disabled");
    chk_int_vector: assert property (
        (q.state == cass_pkg::S_WDATA && q.wr_kind == cass_pkg::WR_SAVE)
        |=> (q.state == cass_pkg::S_RADDR && mem_ad_o == {1'b0, `CASS_VEC_LOC}) ##2
        (q.ip == $past(mem_ad_i[14:0])))
        else $error("handler not loaded");
    chk_wake_halt: assert property (
        (q.state == cass_pkg::S_BOUND && q.halted && irq && !q.rf_rq && !dch)
        |=> !halted)
        else $error("interrupt did not end halt");
    chk_row_step: assert property (
        q.state == cass_pkg::S_REFR |=> q.row == 6'($past(q.row) + 6'h1))
        else $error("refresh row did not step");
    cov_interrupt: cover property (q.state == cass_pkg::S_WADDR && q.wr_kind == cass_pkg::WR_SAVE);
    cov_dch_halted: cover property (q.state == cass_pkg::S_DCH && q.halted);
    cov_skip: cover property (q.state == cass_pkg::S_EXEC && op == 4'(cass_pkg::OP_SKIP));
endmodule : cass_core

// File: tb/cass_mem_model.sv
// partner model: word memory and serial data-channel sender
// assumes the core's synchronous read and write codes on pclk
`timescale 1ns/1ps
module cass_mem_model (
    input  wire logic        pclk,
    input  wire logic [15:0] mem_ad_o,
    input  wire logic        mem_ad_oe,
    input  wire logic [2:0]  mem_ctl,
    output logic      [15:0] mem_ad_i,
    input  wire logic        io_dir,
    input  wire logic        io_clk,
    input  wire logic [15:0] dch_word,
    output logic             io_d1_i,
    output logic             io_d2_i
);
    logic [15:0] mem [0:32767];
    logic [14:0] adr_q  = 15'h0;
    logic [15:0] last_q = 16'h0;
    logic [2:0]  idx_q  = 3'h0;
    logic        rd_q   = 1'b0;
    logic        wr_q   = 1'b0;
    logic        clk_q  = 1'b0;
    logic        tog_q  = 1'b0;
    // bus shows the inverse of the last word when not answering
    assign mem_ad_i = rd_q ? mem[adr_q] : ~last_q;
    // serial frame: d1 high byte, d2 low byte, msb first
    assign io_d1_i = io_dir ? dch_word[{1'b1, ~idx_q}] : tog_q;
    assign io_d2_i = io_dir ? dch_word[{1'b0, ~idx_q}] : ~tog_q;
    always @(posedge pclk) begin
        tog_q <= ~tog_q;
        clk_q <= io_clk;
        rd_q  <= (mem_ctl == 3'h1) && mem_ad_oe;
        wr_q  <= (mem_ctl == 3'h2) && !wr_q;
        if (rd_q)
            last_q <= mem[adr_q];
        if ((mem_ctl == 3'h1 && mem_ad_oe) || (mem_ctl == 3'h2 && !wr_q))
            adr_q <= mem_ad_o[14:0];
        if (mem_ctl == 3'h2 && wr_q)
            mem[adr_q] <= mem_ad_o;
        // next bit after each falling bit clock
        if (!io_dir)
            idx_q <= 3'h0;
        else if (clk_q && !io_clk)
            idx_q <= idx_q + 3'h1;
    end
endmodule : cass_mem_model

// File: tb/tb_top.sv
// self-checking bench of the sequencer core
// assumes cass_core, cass_mem_model and a 100 MHz pclk
`timescale 1ns/1ps
`include "cass_defines.svh"
module tb_top;
    logic        pclk      = 1'b0;
    logic        presetn   = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [7:0]  paddr     = 8'h00;
    logic [31:0] pwdata    = 32'h0;
    logic        pio_req_n = 1'b1;
    logic        dch_req_n = 1'b1;
    logic [5:0]  row       = 6'h0;
    logic [15:0] word      = 16'ha53c;
    logic [31:0] prdata, rd;
    logic [15:0] mem_ad_i, mem_ad_o;
    logic [2:0]  mem_ctl;
    logic        pready, pslverr, err, mem_ad_oe, io_d1_i, io_d2_i, io_dir, io_clk, halted;
    int          fail_count = 0;
    int          tests_run  = 0;
    int          cyc        = 0;
    always #5 pclk = ~pclk;
    cass_core #(.RTC_CYCLES(512), .RF_CYCLES(8)) u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .mem_ad_i, .mem_ad_o, .mem_ad_oe, .mem_ctl, .io_d1_i, .io_d1_o(),
        .io_d1_oe(), .io_d2_i, .io_d2_o(), .io_d2_oe(), .io_dir, .io_clk, .pio_req_n,
        .dch_req_n, .halted);
    cass_mem_model u_mem (.pclk, .mem_ad_o, .mem_ad_oe, .mem_ctl, .mem_ad_i, .io_dir,
        .io_clk, .dch_word(word), .io_d1_i, .io_d2_i);
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask : rdc
    task automatic wh(input logic v);
        for (int i = 0; i < 2000 && halted !== v; i++) @(posedge pclk);
        chk("halted", {31'h0, v}, {31'h0, halted});
    endtask : wh
    task automatic wait_ins(input logic [14:0] ip);
        rd = 32'h0;
        for (int i = 0; i < 40 && rd[15:0] !== u_mem.mem[ip]; i++) apb(1'b0, `CASS_A_INSTR, 32'h0);
        chk("instr", {16'h0, u_mem.mem[ip]}, rd);
    endtask : wait_ins
    task automatic step(input logic [31:0] c, input logic [14:0] ip);
        apb(1'b1, `CASS_A_CMD, c);
        rdc("ip", `CASS_A_IP, {17'h0, ip});
        wait_ins(ip);
    endtask : step
    task automatic regs_test;
        apb(1'b1, 8'h04, 32'h1234ffff);
        rdc("acc1", 8'h04, 32'h0000ffff);
        apb(1'b1, `CASS_A_IP, 32'hffffffff);
        rdc("ip width", `CASS_A_IP, 32'h00007fff);
        apb(1'b0, 8'h34, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
    endtask : regs_test
    task automatic alu_stack;
        apb(1'b1, 8'h00, 32'h0000ffff);
        apb(1'b1, 8'h04, 32'h00000001);
        apb(1'b1, `CASS_A_CMD, 32'h00000408);
        rdc("sum", 8'h00, 32'h0);
        rdc("carry", `CASS_A_FLAGS, 32'h1);
        apb(1'b1, `CASS_A_SP, 32'h000000ff);
        apb(1'b1, `CASS_A_CMD, 32'h5);
        rdc("push", `CASS_A_SP, 32'h00000100);
        apb(1'b0, `CASS_A_STATUS, 32'h0);
        chk("stack_overflow_request_flag", 32'h1, {31'h0, rd[1]});
        apb(1'b1, `CASS_A_CMD, 32'h6);
        rdc("pop", `CASS_A_SP, 32'h000000ff);
        apb(1'b1, `CASS_A_FP, 32'h00000123);
        apb(1'b1, `CASS_A_CMD, 32'h7);
        rdc("ret", `CASS_A_SP, 32'h00000123);
    endtask : alu_stack
    task automatic run_test;
        apb(1'b1, `CASS_A_IP, 32'h00000050);
        apb(1'b1, `CASS_A_FLAGS, 32'h3);
        wh(1'b0);
        wait_ins(15'h0200);
        chk("saved pc", 32'h00000050, {16'h0, u_mem.mem[0]});
        apb(1'b0, `CASS_A_STATUS, 32'h0);
        chk("so clr", 32'h0, {31'h0, rd[1]});
        step(32'h1, 15'h0201);
        step(32'h12, 15'h0203);
        step(32'h2, 15'h0204);
        apb(1'b1, `CASS_A_TARGET, 32'h00007fff);
        step(32'h3, 15'h7fff);
        step(32'h1, 15'h0000);
        apb(1'b1, `CASS_A_CMD, 32'h4);
        wh(1'b1);
    endtask : run_test
    task automatic irq_test;
        u_mem.mem[1] = 16'h0210;
        apb(1'b1, `CASS_A_FLAGS, 32'h4);
        repeat (600) @(posedge pclk);
        apb(1'b0, `CASS_A_STATUS, 32'h0);
        chk("periodic_clock_request_flag", 32'h1, {31'h0, rd[0]});
        chk("rtc held", 32'h1, {31'h0, halted});
        pio_req_n <= 1'b0;
        repeat (20) @(posedge pclk);
        chk("pio masked", 32'h1, {31'h0, halted});
        apb(1'b1, `CASS_A_FLAGS, 32'h6);
        wh(1'b0);
        pio_req_n <= 1'b1;
        wait_ins(15'h0210);
        apb(1'b1, `CASS_A_CMD, 32'h4);
        wh(1'b1);
        u_mem.mem[1] = 16'h0220;
        apb(1'b1, `CASS_A_FLAGS, 32'h2);
        repeat (20) @(posedge pclk);
        chk("no pcen", 32'h1, {31'h0, halted});
        pio_req_n <= 1'b0;
        wh(1'b0);
        pio_req_n <= 1'b1;
        wait_ins(15'h0220);
        apb(1'b1, `CASS_A_CMD, 32'h4);
        wh(1'b1);
    endtask : irq_test
    task automatic dch_test;
        apb(1'b1, `CASS_A_DCHADR, 32'h00000300);
        dch_req_n <= 1'b0;
        for (int i = 0; i < 50 && io_dir !== 1'b1; i++) @(posedge pclk);
        dch_req_n <= 1'b1;
        for (int i = 0; i < 200 && io_dir !== 1'b0; i++) @(posedge pclk);
        repeat (10) @(posedge pclk);
        chk("dch word", 32'h0000a53c, {16'h0, u_mem.mem[15'h0300]});
        rdc("dch adr", `CASS_A_DCHADR, 32'h00000301);
        chk("still halted", 32'h1, {31'h0, halted});
    endtask : dch_test
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (mem_ctl === 3'h4) begin
            chk("refresh row", {26'h0, row}, {16'h0, mem_ad_o});
            row <= row + 6'h1;
        end
        if (cyc == 60000) begin
            fail_count++;
            final_report();
        end
    end
    initial begin
        for (int i = 0; i < 32768; i++) u_mem.mem[i] = ~i[15:0];
        u_mem.mem[1] = 16'h0200;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        regs_test();
        alu_stack();
        run_test();
        irq_test();
        dch_test();
        final_report();
    end
endmodule : tb_top
